// ===== common/arxad_pkg.sv
/*
 Constants for the asynchronous receiver with address detection:
 register offsets, bit positions, reset values and timing counts.
 Assumes an 8-bit register port with registers at small indices.
*/
package arxad_pkg;
    // ****************************************
    // Register offsets (chosen)
    // ****************************************
    localparam logic [3:0] OFS_RX_STATUS_CTRL = 4'h0;
    localparam logic [3:0] OFS_RX_DATA = 4'h1;
    localparam logic [3:0] OFS_TX_STATUS_CTRL = 4'h2;
    localparam logic [3:0] OFS_BAUD_CTRL = 4'h3;
    localparam logic [3:0] OFS_BAUD_DIV_LO = 4'h4;
    localparam logic [3:0] OFS_BAUD_DIV_HI = 4'h5;
    localparam logic [3:0] OFS_IRQ_EN_ONE = 4'h6;
    localparam logic [3:0] OFS_IRQ_FLAG_ONE = 4'h7;
    // ****************************************
    // Receive status and control bits
    // ****************************************
    localparam int BIT_PORT_ENABLE = 7;
    localparam int BIT_RX_NINE_BIT_EN = 6;
    localparam int BIT_RX_CONTINUOUS_EN = 4;
    localparam int BIT_ADDR_DETECT_EN = 3;
    localparam int BIT_FRAME_ERR = 2;
    localparam int BIT_OVERRUN_ERR = 1;
    localparam int BIT_RX_BIT8 = 0;
    // ****************************************
    // Other register bits
    // ****************************************
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_BAUD_HIGH_SPEED = 2;
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_BAUD_WIDE_DIV = 3;
    localparam int BIT_RX_IRQ_EN = 5;
    localparam int BIT_RX_PENDING = 5;
    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] OVERSAMPLE = 4'hf;
    localparam logic [3:0] MID_BIT = 4'h7;
    localparam logic [3:0] VOTE_A = 4'h6;
    localparam logic [3:0] VOTE_B = 4'h8;
    localparam int FIFO_DEPTH = 2;
endpackage

// ===== src/arxad_receiver.sv
/*
 Asynchronous serial receiver with nine-bit address detection,
 two-character receive FIFO, overrun/framing flags and baud divider.
 The receiver hunts for a falling edge, checks the start bit at its
 centre, votes three samples around each data bit centre and hands
 the character over at the centre of the stop bit, so a following
 start edge right after the stop bit is never missed.

 Assumes RX_IN synchronous to REF_CLK and a single-cycle register port.
 Assumes software keeps the register order of the set-up sequence:
 divider and speed selects first, then port enable, then continuous
 enable. Changing the divider mid-character distorts that character.
 Address filtering works on the ninth bit only, so software is
 expected to select nine-bit reception whenever it uses it.
*/
`timescale 1ns/100ps
module arxad_receiver
    import arxad_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Serial line
    input wire logic RX_IN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Interrupt request
    output logic RX_IRQ
);
    typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} arxad_state_type;

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] receive_status_control_q, transmit_status_control_q, bdiv_lo_q, bdiv_hi_q;
    logic bwide_q, irq_en_q;
    logic [7:0] rdata_q;
    logic overrun_err_q;
    logic port_enable, rx_continuous_en, addr_detect_en, rx_nine_bit_en;
    logic rx_on;
    logic pop;
    logic [8:0] head_data;
    logic head_frame_err_flag;
    logic [1:0] count_q;

    assign port_enable = receive_status_control_q[BIT_PORT_ENABLE];
    assign rx_nine_bit_en = receive_status_control_q[BIT_RX_NINE_BIT_EN];
    assign rx_continuous_en = receive_status_control_q[BIT_RX_CONTINUOUS_EN];
    assign addr_detect_en = receive_status_control_q[BIT_ADDR_DETECT_EN];
    assign rx_on = port_enable & ~transmit_status_control_q[BIT_SYNC_MODE] & rx_continuous_en;
    assign pop = RD && ADDR == OFS_RX_DATA && count_q != 2'h0;


    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            receive_status_control_q <= RST_BYTE;
            transmit_status_control_q <= RST_BYTE;
            bdiv_lo_q <= RST_BYTE;
            bdiv_hi_q <= RST_BYTE;
            bwide_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (WR) begin
            case (ADDR)
                OFS_RX_STATUS_CTRL: receive_status_control_q <= WDATA;
                OFS_TX_STATUS_CTRL: transmit_status_control_q <= WDATA;
                OFS_BAUD_DIV_LO: bdiv_lo_q <= WDATA;
                OFS_BAUD_DIV_HI: bdiv_hi_q <= WDATA;
                OFS_BAUD_CTRL: bwide_q <= WDATA[BIT_BAUD_WIDE_DIV];
                OFS_IRQ_EN_ONE: irq_en_q <= WDATA[BIT_RX_IRQ_EN];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Baud divider: one tick per sixteenth bit
    // ****************************************
    logic [15:0] div_q, div_top;
    logic [1:0] pre_q, pre_top;
    logic tick;

    assign div_top = bwide_q ? {bdiv_hi_q, bdiv_lo_q} : {8'h00, bdiv_lo_q};
    // Low speed stretches by four so one tick still means 1/16 bit
    assign pre_top = transmit_status_control_q[BIT_BAUD_HIGH_SPEED] ? 2'h0 : 2'h3;
    assign tick = div_q == 16'h0000 && pre_q == 2'h0;


    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            div_q <= 16'h0000;
            pre_q <= 2'h0;
        end else if (!port_enable) begin
            div_q <= 16'h0000;
            pre_q <= 2'h0;
        end else if (div_q != 16'h0000) begin
            div_q <= div_q - 16'h0001;
        end else begin
            div_q <= div_top;
            pre_q <= (pre_q == 2'h0) ? pre_top : pre_q - 2'h1;
        end
    end

    // ****************************************
    // Data recovery
    // ****************************************
    arxad_state_type state_q;
    logic [3:0] os_q, nbits_q;
    logic [8:0] rx_shifter_q;
    logic [2:0] vote_q;
    logic rx_prev_q, majority, push;
    logic [8:0] push_data;
    logic push_frame_err_flag, accept;

    assign majority = (vote_q[0] & vote_q[1]) | (vote_q[0] & RX_IN) |
                      (vote_q[1] & RX_IN);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            os_q <= 4'h0;
            nbits_q <= 4'h0;
            rx_shifter_q <= 9'h000;
            vote_q <= 3'h7;
            rx_prev_q <= 1'b1;
            push <= 1'b0;
            push_data <= 9'h000;
            push_frame_err_flag <= 1'b0;
        end else begin
            push <= 1'b0;
            rx_prev_q <= RX_IN;
            if (!rx_on) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_IDLE: if (rx_prev_q && !RX_IN) begin
                        state_q <= ST_START;
                        os_q <= 4'h0;
                    end
                    ST_START: if (tick) begin
                        os_q <= os_q + 4'h1;
                        // abandon silently if start not low
                        if (os_q == MID_BIT && RX_IN) begin
                            state_q <= ST_IDLE;
                        end else if (os_q == OVERSAMPLE) begin
                            // Whole start bit, so votes land mid-bit
                            state_q <= ST_DATA;
                            nbits_q <= 4'h0;
                        end
                    end
                    ST_DATA: if (tick) begin
                        os_q <= os_q + 4'h1;
                        if (os_q == VOTE_A) vote_q[0] <= RX_IN;
                        if (os_q == MID_BIT) vote_q[1] <= RX_IN;
                        if (os_q == VOTE_B) begin
                            rx_shifter_q <= {majority, rx_shifter_q[8:1]};
                        end
                        if (os_q == OVERSAMPLE) begin
                            nbits_q <= nbits_q + 4'h1;
                            if (nbits_q == (rx_nine_bit_en ? 4'h8 : 4'h7))
                                state_q <= ST_STOP;
                        end
                    end
                    ST_STOP: if (tick) begin
                        os_q <= os_q + 4'h1;
                        // Stop centre, leaving time for the next edge
                        if (os_q == MID_BIT) begin
                            state_q <= ST_IDLE;
                            push <= 1'b1;
                            // zero stop bit is framing error
                            push_frame_err_flag <= ~RX_IN;
                            push_data <= rx_nine_bit_en ? rx_shifter_q :
                                {1'b0, rx_shifter_q[8:1]};
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // address mode drops bit-8-zero chars, else all kept until overrun
    // Gated by rx_on so no set can meet the overrun clear
    assign accept = push && rx_on && (!addr_detect_en || push_data[8]) &&
                    !overrun_err_q;


    // ****************************************
    // Two-character FIFO with overrun
    // ****************************************

    logic [9:0] fifo_q [DEPTH];
    logic [1:0] rd_q, wr_q;
    logic full;

    assign full = count_q == 2'(DEPTH);
    assign head_data = fifo_q[rd_q[0]][8:0];
    assign head_frame_err_flag = fifo_q[rd_q[0]][9];

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) fifo_q[i] <= 10'h000;
            rd_q <= 2'h0;
            wr_q <= 2'h0;
            count_q <= 2'h0;
        end else if (!port_enable) begin
            rd_q <= 2'h0;
            wr_q <= 2'h0;
            count_q <= 2'h0;
        end else begin
            // two entries; write below full, or when full with a pop
            if (accept && (!full || pop)) begin
                fifo_q[wr_q[0]] <= {push_frame_err_flag, push_data};
                wr_q <= wr_q + 2'h1;
            end
            if (pop) rd_q <= rd_q + 2'h1;
            count_q <= count_q + 2'((accept && (!full || pop)) ? 1 : 0)
                       - 2'(pop ? 1 : 0);
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            overrun_err_q <= 1'b0;
        end else if (!port_enable || !rx_continuous_en) begin
            overrun_err_q <= 1'b0;
        end else if (accept && full && !pop) begin
            overrun_err_q <= 1'b1;
        end
    end

    // ****************************************
    // Read path, one cycle latency
    // ****************************************
    logic rx_pending_flag;

    // pending while buffer holds a character and rx_on is set
    assign rx_pending_flag = count_q != 2'h0 && rx_on;
    assign RX_IRQ = rx_pending_flag & irq_en_q;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= RST_BYTE;
        end else if (RD) begin
            case (ADDR)
                // ninth bit of head reported here
                OFS_RX_STATUS_CTRL: rdata_q <= {receive_status_control_q[7:3], head_frame_err_flag,
                    overrun_err_q, head_data[8]};
                OFS_RX_DATA: rdata_q <= head_data[7:0];
                OFS_TX_STATUS_CTRL: rdata_q <= transmit_status_control_q;
                OFS_BAUD_CTRL: rdata_q <= {1'b0, state_q == ST_IDLE, 2'h0,
                    bwide_q, 3'h0};
                OFS_BAUD_DIV_LO: rdata_q <= bdiv_lo_q;
                OFS_BAUD_DIV_HI: rdata_q <= bdiv_hi_q;
                OFS_IRQ_EN_ONE: rdata_q <= {2'h0, irq_en_q, 5'h00};
                OFS_IRQ_FLAG_ONE: rdata_q <= {2'h0, rx_pending_flag, 5'h00};
                default: rdata_q <= RST_BYTE;
            endcase
        end
    end
    assign RDATA = rdata_q;
endmodule

// ===== testbench/arxad_receiver_properties.sv
/*
 Port checker for the address-detect receiver.
 Assumes the bench's 16-clock bit period for the quiet-line bound.
*/
`timescale 1ns/100ps
module arxad_receiver_properties
    import arxad_pkg::*;
(
    // Watched ports
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RX_IN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic RX_IRQ
);
    // ****************************************
    // Shadow of software writes
    // ****************************************
    logic [7:0] rcs_q;
    logic [7:0] low_q;
    logic en_q;
    logic clean_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rcs_q <= 8'h00;
            en_q <= 1'b0;
            clean_q <= 1'b0;
        end else if (WR && ADDR == OFS_RX_STATUS_CTRL) begin
            rcs_q <= WDATA;
            clean_q <= !WDATA[BIT_PORT_ENABLE]
                || (clean_q && WDATA[BIT_ADDR_DETECT_EN]);
        end else if (WR && ADDR == OFS_IRQ_EN_ONE) begin
            en_q <= WDATA[BIT_RX_IRQ_EN];
        end
    end
    // Saturates so long idle periods never wrap
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST || !RX_IN) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hff) begin
            low_q <= low_q + 8'h01;
        end
    end
    sequence wr_lo;
        WR && ADDR == OFS_BAUD_DIV_LO;
    endsequence
    sequence rd_lo;
        RD && ADDR == OFS_BAUD_DIV_LO;
    endsequence
    div_readback_a:
        assert property (wr_lo ##2 rd_lo |=> RDATA == $past(WDATA, 3))
        else $error("divider readback differs");
    irq_mask_a:
        assert property (!en_q |-> !RX_IRQ)
        else $error("request while disabled");
    port_off_a:
        assert property (!rcs_q[BIT_PORT_ENABLE] |-> !RX_IRQ)
        else $error("request with port off");
    flag_view_a:
        assert property (RD && ADDR == OFS_IRQ_FLAG_ONE && en_q
            |=> RDATA[BIT_RX_PENDING] == $past(RX_IRQ))
        else $error("pending flag read differs");
    overrun_clr_a:
        assert property (RD && ADDR == OFS_RX_STATUS_CTRL
            && !rcs_q[BIT_RX_CONTINUOUS_EN]
            && !$past(rcs_q[BIT_RX_CONTINUOUS_EN])
            |=> !RDATA[BIT_OVERRUN_ERR])
        else $error("overrun kept after clear");
    addr_bit8_a:
        assert property (RD && ADDR == OFS_RX_STATUS_CTRL && clean_q
            && rcs_q[BIT_ADDR_DETECT_EN] && RX_IRQ |=> RDATA[BIT_RX_BIT8])
        else $error("address char without ninth bit");
    rdata_hold_a:
        assert property (!RD |=> $stable(RDATA))
        else $error("read data moved without read");
    quiet_irq_a:
        assert property ($rose(RX_IRQ) && $past(en_q)
            && $past(rcs_q[BIT_RX_CONTINUOUS_EN])
            |-> low_q < 8'hc8)
        else $error("pending without line activity");
endmodule

// ===== testbench/arxad_line_model.sv
/*
 Remote transmitter on the shared line.
 Assumes calls come from one process; line idles high.
*/
`timescale 1ns/100ps
module arxad_line_model #(
    parameter int BIT = 16
) (
    // Clock and line
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    task automatic send(input logic [8:0] d, input logic nine,
        input logic stop);
        logic [10:0] f;
        f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        @(posedge clk);
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            line <= f[i];
            repeat (BIT) @(posedge clk);
        end
        line <= 1'b1;
    endtask
endmodule

// ===== testbench/arxad_receiver_tb.sv
/*
 Self-checking bench for the address-detect receiver.
 Assumes the line model drives RX_IN at 16 clocks a bit.
*/
`timescale 1ns/100ps
module arxad_receiver_tb
    import arxad_pkg::*;
;
    logic REF_CLK, RST, RX_IN, WR, RD, RX_IRQ;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, v, d;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    arxad_receiver u_arxad_receiver (.REF_CLK(REF_CLK), .RST(RST),
        .RX_IN(RX_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RX_IRQ(RX_IRQ));
    arxad_line_model u_arxad_line_model (.clk(REF_CLK), .line(RX_IN));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= dat;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        q = RDATA;
    endtask
    // Waits up to six cycles, ending early only on an expected raised request
    task automatic wait_irq(input logic e);
        int k;
        k = 0;
        while (k < 6 && !(e && RX_IRQ === 1'b1)) begin
            @(negedge REF_CLK);
            k++;
        end
        chk({7'h00, RX_IRQ}, {7'h00, e});
    endtask
    function automatic logic [7:0] st(input logic fe, input logic oe);
        return {5'h12, fe, oe, 1'b0};
    endfunction
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 4'h0;
        WDATA = 8'h00;
        v = 8'($urandom(87));
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        for (int a = 0; a < 10; a++) begin
            rd(4'(a), v);
            if (a != 3) chk(v, RST_BYTE);
        end
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(4'(4 + i % 2), d);
            rd(4'(4 + i % 2), v);
            chk(v, d);
        end
        wr(OFS_BAUD_CTRL, 8'h08);
        rd(OFS_BAUD_CTRL, v);
        chk(v, 8'h48);
        wr(OFS_BAUD_CTRL, 8'h00);
        wr(OFS_BAUD_DIV_LO, 8'h00);
        wr(OFS_TX_STATUS_CTRL, 8'h04);
        wr(OFS_IRQ_EN_ONE, 8'h20);
        wr(OFS_RX_STATUS_CTRL, 8'h90);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            u_arxad_line_model.send({1'b0, d}, 1'b0, i != 3);
            wait_irq(1'b1);
            if (i == 0) begin
                wr(OFS_IRQ_EN_ONE, 8'h00);
                wait_irq(1'b0);
                rd(OFS_IRQ_FLAG_ONE, v);
                chk(v, 8'h20);
                wr(OFS_IRQ_EN_ONE, 8'h20);
            end
            rd(OFS_RX_STATUS_CTRL, v);
            chk(v & 8'hfe, st(i == 3, 1'b0));
            rd(OFS_RX_DATA, v);
            chk(v, d);
            wait_irq(1'b0);
        end
        for (int i = 0; i < 3; i++)
            u_arxad_line_model.send({1'b0, 8'(8'h31 + i)}, 1'b0, 1'b1);
        repeat (4) @(negedge REF_CLK);
        rd(OFS_RX_STATUS_CTRL, v);
        chk(v & 8'hfe, st(1'b0, 1'b1));
        rd(OFS_RX_DATA, v);
        chk(v, 8'h31);
        rd(OFS_RX_DATA, v);
        chk(v, 8'h32);
        wr(OFS_RX_STATUS_CTRL, 8'h80);
        rd(OFS_RX_STATUS_CTRL, v);
        chk(v & 8'h06, 8'h00);
        wr(OFS_RX_STATUS_CTRL, 8'h90);
        wr(OFS_TX_STATUS_CTRL, 8'h14);
        u_arxad_line_model.send(9'h05a, 1'b0, 1'b1);
        wait_irq(1'b0);
        wr(OFS_TX_STATUS_CTRL, 8'h04);
        wr(OFS_RX_STATUS_CTRL, 8'h00);
        wr(OFS_RX_STATUS_CTRL, 8'hd8);
        u_arxad_line_model.send(9'h055, 1'b1, 1'b1);
        wait_irq(1'b0);
        u_arxad_line_model.send(9'h1a5, 1'b1, 1'b1);
        wait_irq(1'b1);
        rd(OFS_RX_STATUS_CTRL, v);
        chk(v & 8'h07, 8'h01);
        rd(OFS_RX_DATA, v);
        chk(v, 8'ha5);
        wr(OFS_RX_STATUS_CTRL, 8'hd0);
        u_arxad_line_model.send(9'h03c, 1'b1, 1'b1);
        wait_irq(1'b1);
        rd(OFS_RX_STATUS_CTRL, v);
        chk(v & 8'h07, 8'h00);
        rd(OFS_RX_DATA, v);
        chk(v, 8'h3c);
        wr(OFS_RX_STATUS_CTRL, 8'hd8);
        u_arxad_line_model.send(9'h066, 1'b1, 1'b1);
        wait_irq(1'b0);
        complete_run();
    end
endmodule
bind arxad_receiver arxad_receiver_properties u_props (.REF_CLK(REF_CLK),
    .RST(RST), .RX_IN(RX_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RX_IRQ(RX_IRQ));
